/* apdu_map.svh */
// Contract
// - Each command-response pair is one of four cases by data presence.
// - Class upper nibble 8 is proprietary, 0 inter-industry, others out of scope.
// - Class lower nibble selects secure messaging and logical channel.
// - Instruction byte decodes together with class into the twelve known commands.
// - Own proprietary instructions should not be placed under class 8x.
// - Every response ends with two status bytes, first then second.
// - Normal completion is 90 00; other second bytes with 90 reserved.
// - Warnings use 62 memory unchanged, 63 memory changed.
// - Execution errors use 64 00 unchanged, 65 changed.
// - Checking errors 6700, 68xx, 69xx, 6Axx, 6D00, 6E00, 6F00.
// - Transport pairs 61xx and 6Cxx are never delivered.
// - Only first status byte 6x or 90 is valid.
// - With 62, second byte is 00, 81, 83 or 84.
// - With 63, second byte is 00 or Cx counter 0 to 15.
// - With 65, second byte is 00 or 81.
// - With 68, second byte is 00, 81 or 82.
// - With 69, second byte is 00, 81 to 85, 87 or 88.
// - With 6A, second byte is 00, 80 to 83, 85 to 88.
// - Command data is plain elements; response data is objects or template.
// - Command is four-byte header then optional length, data, expected length.
// - Expected length zero requests 256 bytes.
`ifndef APDU_MAP_SVH
`define APDU_MAP_SVH
`define CLA_HI_PROP     4'h8
`define CLA_HI_INTER    4'h0
`define INS_APP_BLOCK   8'h1e
`define INS_APP_UNBLOCK 8'h18
`define INS_CARD_BLOCK  8'h16
`define INS_GEN_AC      8'hae
`define INS_GET_DATA    8'hca
`define INS_GET_PROC    8'ha8
`define INS_PIN_CHANGE  8'h1a
`define INS_EXT_AUTH    8'h82
`define INS_INT_AUTH    8'h88
`define INS_READ_REC    8'hb2
`define INS_SELECT      8'ha4
`define INS_VERIFY      8'h20
`define SW1_OK          8'h90
`define SW1_WARN_NC     8'h62
`define SW1_WARN_CH     8'h63
`define SW1_EXEC_NC     8'h64
`define SW1_EXEC_CH     8'h65
`define SW1_LEN         8'h67
`define SW1_CLA_FN      8'h68
`define SW1_NOT_ALLOW   8'h69
`define SW1_WRONG_P     8'h6a
`define SW1_INS_BAD     8'h6d
`define SW1_CLA_BAD     8'h6e
`define SW1_NO_DIAG     8'h6f
`define SW1_MORE        8'h61
`define SW1_WRONG_LE    8'h6c
`define SW_HI_6X        4'h6
`define SW2_NONE        8'h00
`define SW2_CNT_HI      4'hc
`define LE_MAX          9'h100
`endif

/* apdu_pkg.sv */
package apdu_pkg;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_APP_BLOCK, CMD_APP_UNBLOCK, CMD_CARD_BLOCK, CMD_GEN_AC,
      CMD_GET_DATA, CMD_GET_PROC, CMD_PIN_CHANGE, CMD_EXT_AUTH, CMD_INT_AUTH,
      CMD_READ_REC, CMD_SELECT, CMD_VERIFY
   } cmd_t;
   typedef enum logic [1:0] {CLS_OTHER, CLS_INTER, CLS_PROP} cls_t;
   typedef enum logic [1:0] {CASE1, CASE2, CASE3, CASE4} apdu_case_t;
   typedef struct packed {
      logic [7:0] cla;
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic       lc_present;
      logic [7:0] lc;
      logic       le_present;
      logic [7:0] le;
   } cmd_hdr_t;
   typedef struct packed {
      cmd_t       cmd;
      cls_t       cls;
      logic [3:0] chan_sm;
      apdu_case_t acase;
      logic [8:0] resp_max;
      logic       p1_zero;
      logic       p2_zero;
      logic       reject;
   } cmd_info_t;
   typedef struct packed {
      logic [7:0] sw1;
      logic [7:0] sw2;
   } status_t;
endpackage

/* apdu_status_check.sv */
`timescale 1ns/1ps
`include "apdu_map.svh"
module apdu_status_check
   import apdu_pkg::*;
(
   input  wire apdu_pkg::status_t sw_i,
   output logic                   legal_o,
   output logic                   reserved_o
);
   always_comb begin
      legal_o    = 1'b0;
      reserved_o = 1'b0;
      case (sw_i.sw1)
         `SW1_OK:      legal_o = (sw_i.sw2 == `SW2_NONE);
         `SW1_WARN_NC: legal_o = (sw_i.sw2 == `SW2_NONE) || (sw_i.sw2 == 8'h81)
                                 || (sw_i.sw2 == 8'h83) || (sw_i.sw2 == 8'h84);
         `SW1_WARN_CH: legal_o = (sw_i.sw2 == `SW2_NONE)
                                 || (sw_i.sw2[7:4] == `SW2_CNT_HI);
         `SW1_EXEC_NC: legal_o = (sw_i.sw2 == `SW2_NONE);
         `SW1_EXEC_CH: legal_o = (sw_i.sw2 == `SW2_NONE) || (sw_i.sw2 == 8'h81);
         `SW1_LEN,
         `SW1_INS_BAD,
         `SW1_CLA_BAD,
         `SW1_NO_DIAG: legal_o = (sw_i.sw2 == `SW2_NONE);
         `SW1_CLA_FN:  legal_o = (sw_i.sw2 == `SW2_NONE) || (sw_i.sw2 == 8'h81)
                                 || (sw_i.sw2 == 8'h82);
         `SW1_NOT_ALLOW: legal_o = (sw_i.sw2 == `SW2_NONE)
                                 || ((sw_i.sw2 >= 8'h81) && (sw_i.sw2 <= 8'h85))
                                 || (sw_i.sw2 == 8'h87) || (sw_i.sw2 == 8'h88);
         `SW1_WRONG_P: legal_o = (sw_i.sw2 == `SW2_NONE)
                                 || ((sw_i.sw2 >= 8'h80) && (sw_i.sw2 <= 8'h83))
                                 || ((sw_i.sw2 >= 8'h85) && (sw_i.sw2 <= 8'h88));
         default: legal_o = 1'b0;
      endcase
      // First byte family is acceptable; only the qualifier is off
      if (!legal_o && (sw_i.sw1 == `SW1_OK || (sw_i.sw1[7:4] == `SW_HI_6X
          && sw_i.sw1 != `SW1_MORE && sw_i.sw1 != `SW1_WRONG_LE))) begin
         reserved_o = 1'b1;
      end
   end
endmodule

/* apdu_class_status_coder.sv */
`timescale 1ns/1ps
`include "apdu_map.svh"
module apdu_class_status_coder
   import apdu_pkg::*;
(
   input  wire logic               CLOCK_I,
   input  wire logic               RST_B_I,
   input  wire logic               CMD_VALID_I,
   input  wire apdu_pkg::cmd_hdr_t CMD_I,
   input  wire logic               STS_VALID_I,
   input  wire apdu_pkg::status_t  STS_I,
   output logic                    INFO_VALID_O,
   output apdu_pkg::cmd_info_t     INFO_O,
   output logic                    SW_VALID_O,
   output apdu_pkg::status_t       SW_O,
   output logic                    SW_FIXED_O
);
   import apdu_pkg::*;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic cls_t class_of(input logic [7:0] cla);
      if (cla[7:4] == `CLA_HI_PROP) begin
         class_of = CLS_PROP;
      end else if (cla[7:4] == `CLA_HI_INTER) begin
         class_of = CLS_INTER;
      end else begin
         class_of = CLS_OTHER;
      end
   endfunction

   function automatic cmd_t cmd_of(input cls_t cls, input logic [7:0] ins);
      cmd_of = CMD_NONE;
      if (cls == CLS_PROP) begin
         case (ins)
            `INS_APP_BLOCK:   cmd_of = CMD_APP_BLOCK;
            `INS_APP_UNBLOCK: cmd_of = CMD_APP_UNBLOCK;
            `INS_CARD_BLOCK:  cmd_of = CMD_CARD_BLOCK;
            `INS_GEN_AC:      cmd_of = CMD_GEN_AC;
            `INS_GET_DATA:    cmd_of = CMD_GET_DATA;
            `INS_GET_PROC:    cmd_of = CMD_GET_PROC;
            `INS_PIN_CHANGE:  cmd_of = CMD_PIN_CHANGE;
            default:          cmd_of = CMD_NONE;
         endcase
      end else if (cls == CLS_INTER) begin
         case (ins)
            `INS_EXT_AUTH: cmd_of = CMD_EXT_AUTH;
            `INS_INT_AUTH: cmd_of = CMD_INT_AUTH;
            `INS_READ_REC: cmd_of = CMD_READ_REC;
            `INS_SELECT:   cmd_of = CMD_SELECT;
            `INS_VERIFY:   cmd_of = CMD_VERIFY;
            default:       cmd_of = CMD_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Command classification
   // ----------------------------------------
   logic      info_valid_q, info_valid_d;
   cmd_info_t info_q, info_d;
   status_t   rej_sw_q, rej_sw_d;
   logic      rej_pend_q, rej_pend_d;

   always_comb begin
      info_valid_d = CMD_VALID_I;
      info_d       = info_q;
      rej_sw_d     = rej_sw_q;
      rej_pend_d   = rej_pend_q;
      if (CMD_VALID_I) begin
         info_d.cls      = class_of(CMD_I.cla);
         info_d.chan_sm  = CMD_I.cla[3:0];
         info_d.cmd      = cmd_of(info_d.cls, CMD_I.ins);
         info_d.acase    = apdu_case_t'({CMD_I.lc_present, CMD_I.le_present});
         info_d.resp_max = !CMD_I.le_present ? 9'h000
                         : (CMD_I.le == 8'h00) ? `LE_MAX : {1'b0, CMD_I.le};
         info_d.p1_zero  = (CMD_I.p1 == 8'h00);
         info_d.p2_zero  = (CMD_I.p2 == 8'h00);
         info_d.reject   = (info_d.cmd == CMD_NONE);
         rej_pend_d      = info_d.reject;
         if (info_d.cls == CLS_OTHER) begin
            rej_sw_d = '{sw1: `SW1_CLA_BAD, sw2: `SW2_NONE};
         end else begin
            rej_sw_d = '{sw1: `SW1_INS_BAD, sw2: `SW2_NONE};
         end
      end else begin
         rej_pend_d = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         info_valid_q <= 1'b0;
         info_q       <= '0;
         rej_sw_q     <= '0;
         rej_pend_q   <= 1'b0;
      end else begin
         info_valid_q <= info_valid_d;
         info_q       <= info_d;
         rej_sw_q     <= rej_sw_d;
         rej_pend_q   <= rej_pend_d;
      end
   end

   assign INFO_VALID_O = info_valid_q;
   assign INFO_O       = info_q;

   // ----------------------------------------
   // Status trailer builder
   // ----------------------------------------
   logic legal;
   logic reserved;

   apdu_status_check u_check (
      .sw_i       (STS_I),
      .legal_o    (legal),
      .reserved_o (reserved)
   );

   logic    sw_valid_q, sw_valid_d;
   status_t sw_q, sw_d;
   logic    fixed_q, fixed_d;

   // A decode reject takes priority over the processing status in the same cycle,
   // because the command never reached processing.
   always_comb begin
      sw_valid_d = 1'b0;
      sw_d       = sw_q;
      fixed_d    = 1'b0;
      if (rej_pend_q) begin
         sw_valid_d = 1'b1;
         sw_d       = rej_sw_q;
      end else if (STS_VALID_I) begin
         sw_valid_d = 1'b1;
         if (legal) begin
            sw_d = STS_I;
         end else if (reserved) begin
            // Unknown qualifier: keep the first byte, clear the second, except with 63 the second becomes Cx keeping its low nibble
            sw_d    = '{sw1: STS_I.sw1, sw2: `SW2_NONE};
            fixed_d = 1'b1;
            if (STS_I.sw1 == `SW1_WARN_CH) begin
               sw_d.sw2 = {`SW2_CNT_HI, STS_I.sw2[3:0]};
            end
         end else begin
            // Transport-only first bytes and first bytes outside 6x and 90 never leave the block
            sw_d    = '{sw1: `SW1_NO_DIAG, sw2: `SW2_NONE};
            fixed_d = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         sw_valid_q <= 1'b0;
         sw_q       <= '0;
         fixed_q    <= 1'b0;
      end else begin
         sw_valid_q <= sw_valid_d;
         sw_q       <= sw_d;
         fixed_q    <= fixed_d;
      end
   end

   assign SW_VALID_O = sw_valid_q;
   assign SW_O       = sw_q;
   assign SW_FIXED_O = fixed_q;
endmodule

/* apdu_terminal_model.sv */
`timescale 1ns/1ps
module apdu_terminal_model
   import apdu_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               send_i,
   input  wire logic [7:0]         cla_i,
   input  wire logic [7:0]         ins_i,
   input  wire logic               lc_i,
   input  wire logic               le_i,
   output logic                    valid_o,
   output apdu_pkg::cmd_hdr_t      cmd_o
);
   // Unused parameter bytes go out as zero, Le as zero when present
   always_ff @(posedge clk_i) begin
      valid_o <= send_i;
      cmd_o   <= '{cla_i, ins_i, 8'h00, 8'h00,
                   lc_i, lc_i ? 8'h04 : 8'h00, le_i, 8'h00};
   end
endmodule

/* apdu_class_status_coder_assertions.sv */
`timescale 1ns/1ps
module apdu_class_status_coder_assertions
   import apdu_pkg::*;
(
   input wire logic               CLOCK_I,
   input wire logic               RST_B_I,
   input wire logic               CMD_VALID_I,
   input wire apdu_pkg::cmd_hdr_t CMD_I,
   input wire logic               STS_VALID_I,
   input wire apdu_pkg::status_t  STS_I,
   input wire logic               INFO_VALID_O,
   input wire apdu_pkg::cmd_info_t INFO_O,
   input wire logic               SW_VALID_O,
   input wire apdu_pkg::status_t  SW_O,
   input wire logic               SW_FIXED_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   a_info_one_late: assert property (CMD_VALID_I |=> INFO_VALID_O)
      else $error("info late");
   a_info_no_extra: assert property (!CMD_VALID_I |=> !INFO_VALID_O)
      else $error("info extra");
   a_case_code: assert property (CMD_VALID_I |=>
      INFO_O.acase == $past({CMD_I.lc_present, CMD_I.le_present}))
      else $error("case");
   a_chan_nibble: assert property (CMD_VALID_I |=>
      INFO_O.chan_sm == $past(CMD_I.cla[3:0]))
      else $error("chan");
   a_class_sort: assert property (CMD_VALID_I && CMD_I.cla[7:4] == 4'h8 |=>
      INFO_O.cls == CLS_PROP)
      else $error("cls");
   a_le_max: assert property (CMD_VALID_I && CMD_I.le_present && CMD_I.le == 8'h00 |=>
      INFO_O.resp_max == 9'h100)
      else $error("le");
   a_no_transport: assert property (SW_VALID_O |->
      SW_O.sw1 != 8'h61 && SW_O.sw1 != 8'h6c)
      else $error("transport sw");
   a_sw1_legal: assert property (SW_VALID_O |->
      SW_O.sw1[7:4] == 4'h6 || SW_O.sw1 == 8'h90)
      else $error("sw1");
   a_ok_clean: assert property (SW_VALID_O && SW_O.sw1 == 8'h90 |->
      SW_O.sw2 == 8'h00)
      else $error("ok sw2");
   a_reject_cls: assert property (INFO_VALID_O && INFO_O.cls == CLS_OTHER |=>
      SW_VALID_O && SW_O == 16'h6e00)
      else $error("cls reject");
   a_ok_pass: assert property (STS_VALID_I && STS_I == 16'h9000 && !INFO_VALID_O |=>
      SW_VALID_O && !SW_FIXED_O)
      else $error("ok pass");
endmodule
bind apdu_class_status_coder apdu_class_status_coder_assertions i_chk (.*);

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin \
   check_count++; \
   if ((a) !== (b)) begin \
      fail_count++; \
      $display("BAD %0t mismatch", $time); \
   end \
end
module testbench;
   import apdu_pkg::*;
   logic clk = 0, rst_b = 0, send = 0, lc = 0, le = 0, sts_v = 0, cv, iv, swv, fix;
   logic [7:0] cla = 8'h00, ins = 8'h00;
   cmd_hdr_t cmd;
   status_t sts = '0, sw;
   cmd_info_t info;
   int fail_count = 0, check_count = 0, cyc = 0;
   localparam logic [7:0] INS_T [0:11] = '{8'h1e, 8'h18, 8'h16, 8'hae, 8'hca, 8'ha8, 8'h1a,
      8'h82, 8'h88, 8'hb2, 8'ha4, 8'h20};
   // Input, expected trailer, expected fixed flag
   localparam logic [32:0] ST [0:20] = '{{32'h9000_9000, 1'b0}, {32'h9012_9000, 1'b1},
      {32'h6281_6281, 1'b0}, {32'h6285_6200, 1'b1}, {32'h63c5_63c5, 1'b0},
      {32'h6400_6400, 1'b0}, {32'h6401_6400, 1'b1}, {32'h6581_6581, 1'b0},
      {32'h6582_6500, 1'b1}, {32'h6700_6700, 1'b0}, {32'h6882_6882, 1'b0},
      {32'h6883_6800, 1'b1}, {32'h6988_6988, 1'b0}, {32'h6986_6900, 1'b1},
      {32'h6a87_6a87, 1'b0}, {32'h6a84_6a00, 1'b1}, {32'h6d00_6d00, 1'b0},
      {32'h6f00_6f00, 1'b0}, {32'h6105_6f00, 1'b1}, {32'h6c10_6f00, 1'b1},
      {32'h7000_6f00, 1'b1}};
   always #25 clk = ~clk;
   apdu_terminal_model i_apdu_terminal_model (.clk_i(clk), .send_i(send), .cla_i(cla),
      .ins_i(ins), .lc_i(lc), .le_i(le), .valid_o(cv), .cmd_o(cmd));
   apdu_class_status_coder i_apdu_class_status_coder (.CLOCK_I(clk), .RST_B_I(rst_b),
      .CMD_VALID_I(cv), .CMD_I(cmd), .STS_VALID_I(sts_v), .STS_I(sts), .INFO_VALID_O(iv),
      .INFO_O(info), .SW_VALID_O(swv), .SW_O(sw), .SW_FIXED_O(fix));
   task automatic test_done();
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Command goes out through the terminal model, info is checked one cycle after take
   task automatic send_cmd(input logic [7:0] c, input logic [7:0] i, input logic l, input logic e);
      @(posedge clk);
      cla <= c;
      ins <= i;
      lc <= l;
      le <= e;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(iv, 1'b1)
   endtask
   task automatic known_cmds();
      for (int k = 0; k < 12; k++) begin
         send_cmd(k < 7 ? 8'h80 + k[7:0] : k[7:0], INS_T[k], 1'b0, 1'b0);
         `CHK(info.cmd, cmd_t'(k + 1))
         `CHK(info.cls, k < 7 ? CLS_PROP : CLS_INTER)
         `CHK(info.chan_sm, k[3:0])
         `CHK(info.reject, 1'b0)
      end
   endtask
   task automatic reject_cmds();
      send_cmd(8'h30, 8'ha4, 1'b0, 1'b0);
      `CHK(info.cls, CLS_OTHER)
      @(posedge clk);
      #1;
      `CHK({swv, sw}, {1'b1, 16'h6e00})
      send_cmd(8'h80, 8'h20, 1'b0, 1'b0);
      `CHK(info.reject, 1'b1)
      @(posedge clk);
      #1;
      `CHK({swv, sw}, {1'b1, 16'h6d00})
   endtask
   task automatic data_cases();
      for (int k = 0; k < 4; k++) begin
         send_cmd(8'h00, 8'hb2, k[1], k[0]);
         `CHK(info.acase, apdu_case_t'(k))
         `CHK(info.resp_max, k[0] ? 9'h100 : 9'h000)
         `CHK({info.p1_zero, info.p2_zero}, 2'b11)
      end
   endtask
   // Back-to-back trailers, each checked in its one valid cycle
   task automatic trailers();
      for (int k = 0; k < 21; k++) begin
         @(posedge clk);
         sts_v <= 1'b1;
         sts <= ST[k][32:17];
         #1;
         if (k > 0) begin
            `CHK({swv, sw.sw1}, {1'b1, ST[k-1][16:9]})
            `CHK({sw.sw2, fix}, ST[k-1][8:0])
         end
      end
      @(posedge clk);
      sts_v <= 1'b0;
      #1;
      `CHK({swv, sw, fix}, {1'b1, ST[20][16:0]})
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      known_cmds();
      reject_cmds();
      data_cases();
      trailers();
      test_done();
   end
endmodule
